// ==== highway_line_model.sv ====
// far side of the highway: bit clock, frame sync and redundant receive lines
`timescale 1ns/1ps
module highway_line_model #(
    parameter int BITS = 256
) (
    // fault control
    input wire logic [1:0] skew_in,
    // highway
    output logic clock_out,
    output logic sync_out,
    output logic [3:0] line_out
);
    int pos;
    logic [1:0] d;

    // highway clocks run continuously, so the clock never stops between frames
    initial begin
        clock_out = 1'b0;
        sync_out = 1'b0;
        line_out = 4'h0;
        pos = 0;
        // keep highway edges off the system clock edges so sampling order is fixed
        #1;
        forever begin
            #62.5 clock_out = 1'b1;
            #62.5 clock_out = 1'b0;
            pos = (pos + 1) % BITS;
            // sync rises away from the rising clock edge
            sync_out = (pos == 0);
            d = 2'($urandom);
            // skew inverts the spare line of a pair to fake a line fault
            line_out = {d[1] ^ skew_in[1], d[1], d[0] ^ skew_in[0], d[0]};
        end
    end
endmodule : highway_line_model

// ==== highway_port_config.sv ====
// highway port: framing offsets, line selection, standby, test loop, line compare
`timescale 1ns/1ps
module highway_port_config
    import highway_port_pkg::*;
(
    // system
    input wire logic clock_in,
    input wire logic reset_in,
    // avalon-mm slave, word addressed
    input wire logic [2:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // highway pins
    input wire logic highway_clock_in,
    input wire logic frame_sync_in,
    input wire logic [3:0] rx_line_in,
    output pin_group_t tx_pin_out,
    output logic [3:0] tristate_control_pin_out,
    // upstream memory side
    input wire logic [3:0] tx_bit_in,
    input wire logic [3:0] tx_tristate_in,
    output logic tx_tick_out,
    output logic [9:0] up_bit_pos_out,
    // downstream memory side
    output logic [3:0] rx_bit_out,
    output logic rx_valid_out,
    output logic [9:0] down_bit_pos_out,
    output logic [1:0] mismatch_out
);
    // registers
    logic [7:0] down_off_q;
    logic [7:0] up_off_q;
    logic [7:0] shift_ctrl_q;
    logic [7:0] hw_mode_q;
    logic [7:0] op_mode_q;
    logic [9:0] frame_len_q;
    logic [1:0] mismatch_q;
    logic ack_q;
    logic [31:0] rdata_q;
    // highway state
    logic hc_prev_q;
    logic fs_samp_q;
    logic [9:0] down_pos_q;
    logic [9:0] up_pos_q;
    pin_group_t tx_q;
    logic [3:0] rx_bit_q;
    logic rx_valid_q;
    logic [5:0] pins_s;

    function automatic logic [9:0] wrap_sum(logic [11:0] s, logic [10:0] n);
        logic [11:0] t;
        t = s;
        if (t >= {1'h0, n}) begin
            t = t - {1'h0, n};
        end
        if (t >= {1'h0, n}) begin
            t = t - {1'h0, n};
        end
        return t[9:0];
    endfunction : wrap_sum

    // offset in bit units: the masked low bits drop out, the mode sets the scale
    function automatic logic [9:0] mask_off(hw_mode_t m, logic [9:0] o);
        case (m)
            MODE_0: mask_off = {2'h0, o[9:2]};
            MODE_2: mask_off = o;
            default: mask_off = {1'h0, o[9:1]};
        endcase
    endfunction : mask_off

    function automatic logic [9:0] k_down(hw_mode_t m);
        case (m)
            MODE_0: k_down = DOWN_K_M0;
            MODE_2: k_down = DOWN_K_M2;
            default: k_down = DOWN_K_M13;
        endcase
    endfunction : k_down

    function automatic logic [9:0] k_up(hw_mode_t m);
        case (m)
            MODE_0: k_up = UP_K_M0;
            MODE_2: k_up = UP_K_M2;
            default: k_up = UP_K_M13;
        endcase
    endfunction : k_up

    // logical ports onto physical pins; tris high means no drive this slot
    function automatic pin_group_t tx_map(hw_mode_t m, logic [3:0] b, logic [3:0] tr);
        pin_group_t p;
        p.level = b;
        p.oe = ~tr;
        case (m)
            MODE_0: p = p;
            MODE_1: p = {1'h0, b[1], 1'h0, b[0], 1'h0, ~tr[1], 1'h0, ~tr[0]};
            MODE_2: p = {3'h0, b[0], 3'h0, ~tr[0]};
            MODE_3: p = {b[1], b[1], b[0], b[0], ~tr[1], ~tr[1], ~tr[0], ~tr[0]};
            default: p = p;
        endcase
        return p;
    endfunction : tx_map

    // physical receive lines onto logical ports
    function automatic logic [3:0] rx_map(hw_mode_t m, logic [1:0] ais, logic [3:0] l);
        case (m)
            MODE_0: rx_map = l; // select bits unused here
            MODE_2: rx_map = {3'h0, ais[1] ? l[2] : l[3]};
            default: rx_map = {2'h0, ais[1] ? l[2] : l[3], ais[0] ? l[0] : l[1]};
        endcase
    endfunction : rx_map

    pin_sync u_sync (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .pins_in({highway_clock_in, frame_sync_in, rx_line_in}),
        .pins_out(pins_s)
    );

    // decoded controls
    wire hw_mode_t mode = hw_mode_t'(hw_mode_q[HM_MODE +: 2]);
    wire logic [1:0] ais = hw_mode_q[HM_AIS +: 2];
    wire logic [1:0] aic = hw_mode_q[HM_AIC +: 2];
    wire logic sync_edge = hw_mode_q[HM_SYNC_EDGE];
    wire logic tx_edge = shift_ctrl_q[SC_TX_EDGE];
    wire logic rx_edge = shift_ctrl_q[SC_RX_EDGE];
    wire logic port_active = op_mode_q[OM_PORT_ACTIVE];
    wire logic test_loop = op_mode_q[OM_TEST_LOOP];
    wire logic hc_s = pins_s[5];
    wire logic fs_s = pins_s[4];
    wire logic [3:0] rx_s = pins_s[3:0];

    // frame offsets and the bit numbers they mark
    wire logic [10:0] frame_bit_count = {1'h0, frame_len_q} + 11'h001;
    wire logic [9:0] down_off = mask_off(mode, {down_off_q, shift_ctrl_q[SC_DOWN_LO +: 2]});
    wire logic [9:0] up_off = mask_off(mode, {up_off_q, shift_ctrl_q[SC_UP_LO +: 2]});
    wire logic [9:0] down_target = wrap_sum({2'h0, down_off} + {2'h0, k_down(mode)}, frame_bit_count);
    wire logic [9:0] up_target = wrap_sum({2'h0, up_off} + {1'h0, frame_bit_count} - {2'h0, k_up(mode)}, frame_bit_count);

    // edge events of the sampled highway clock
    wire logic hc_rise = hc_s & ~hc_prev_q;
    wire logic hc_fall = ~hc_s & hc_prev_q;
    wire logic fs_tick = sync_edge ? hc_rise : hc_fall;
    wire logic tx_tick = tx_edge ? hc_rise : hc_fall;
    wire logic rx_tick = rx_edge ? hc_rise : hc_fall;
    wire logic frame_start = fs_tick & fs_s & ~fs_samp_q;

    // receive path runs in standby too
    wire logic [3:0] rx_src = test_loop ? tx_q.level : rx_s;
    wire logic [3:0] rx_sel = rx_map(mode, ais, rx_src);
    // compare physical lines, not the selected ones
    wire logic [1:0] diff = {rx_src[2] ^ rx_src[3], rx_src[0] ^ rx_src[1]} & aic & {2{rx_tick}};
    wire pin_group_t tx_next = tx_map(mode, tx_bit_in, tx_tristate_in);
    wire logic [3:0] tx_en = tx_q.oe & {4{port_active}};

    // bus decode
    wire logic req = avs_read_in | avs_write_in;
    wire logic wr_ok = avs_write_in & ack_q;
    wire logic wr_b0 = wr_ok & avs_byteenable_in[0];
    wire logic wr_b1 = wr_ok & avs_byteenable_in[1];
    wire logic [7:0] wd = avs_writedata_in[7:0];
    wire logic [1:0] mm_clear = (wr_b0 && avs_address_in == REG_STATUS) ? wd[1:0] : 2'h0;
    wire logic [31:0] status_word = {29'h0, fs_samp_q, mismatch_q};
    wire logic [31:0] target_word = {6'h00, up_target, 6'h00, down_target};
    wire logic [31:0] rd_word =
        (avs_address_in == REG_DOWN_OFFSET) ? {24'h000000, down_off_q} :
        (avs_address_in == REG_UP_OFFSET) ? {24'h000000, up_off_q} :
        (avs_address_in == REG_SHIFT_CTRL) ? {24'h000000, shift_ctrl_q} :
        (avs_address_in == REG_HW_MODE) ? {24'h000000, hw_mode_q} :
        (avs_address_in == REG_OP_MODE) ? {24'h000000, op_mode_q} :
        (avs_address_in == REG_FRAME_LEN) ? {22'h000000, frame_len_q} :
        (avs_address_in == REG_STATUS) ? status_word : target_word;

    // every request answers on its second edge
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            ack_q <= 1'h0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q <= req & ~ack_q;
            rdata_q <= (req & ~ack_q) ? rd_word : rdata_q;
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            down_off_q <= BYTE_RST;
            up_off_q <= BYTE_RST;
            shift_ctrl_q <= BYTE_RST;
            hw_mode_q <= BYTE_RST;
            op_mode_q <= BYTE_RST;
            frame_len_q <= FRAME_LEN_RST;
        end else begin
            if (wr_b0 && avs_address_in == REG_DOWN_OFFSET) down_off_q <= wd;
            if (wr_b0 && avs_address_in == REG_UP_OFFSET) up_off_q <= wd;
            if (wr_b0 && avs_address_in == REG_SHIFT_CTRL) shift_ctrl_q <= wd;
            if (wr_b0 && avs_address_in == REG_HW_MODE) hw_mode_q <= wd;
            if (wr_b0 && avs_address_in == REG_OP_MODE) op_mode_q <= wd;
            if (wr_b0 && avs_address_in == REG_FRAME_LEN) frame_len_q[7:0] <= wd;
            if (wr_b1 && avs_address_in == REG_FRAME_LEN) frame_len_q[9:8] <= avs_writedata_in[9:8];
        end
    end

    // a mismatch in the clearing cycle survives the clear
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            mismatch_q <= 2'h0;
        end else begin
            mismatch_q <= (mismatch_q & ~mm_clear) | diff;
        end
    end

    // frame positions; free-running modulo frame length without sync
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            hc_prev_q <= 1'h0;
            fs_samp_q <= 1'h0;
            down_pos_q <= 10'h000;
            up_pos_q <= 10'h000;
        end else begin
            hc_prev_q <= hc_s;
            fs_samp_q <= fs_tick ? fs_s : fs_samp_q;
            if (frame_start) begin
                down_pos_q <= down_off;
                up_pos_q <= up_off;
            end else if (hc_rise) begin
                down_pos_q <= wrap_sum({2'h0, down_pos_q} + 12'h001, frame_bit_count);
                up_pos_q <= wrap_sum({2'h0, up_pos_q} + 12'h001, frame_bit_count);
            end
        end
    end

    // launch and sample on the selected edges
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            tx_q <= '0;
            rx_bit_q <= 4'h0;
            rx_valid_q <= 1'h0;
        end else begin
            tx_q <= tx_tick ? tx_next : tx_q;
            rx_bit_q <= rx_tick ? rx_sel : rx_bit_q;
            rx_valid_q <= rx_tick;
        end
    end

    // control pins are active low; outside mode 0, pins 1 and 3 carry the select bits
    always_comb begin
        tristate_control_pin_out = ~tx_en;
        case (mode)
            MODE_0: tristate_control_pin_out = ~tx_en;
            MODE_2: tristate_control_pin_out = {ais[1], 1'h1, ais[0], ~tx_en[0]};
            default: tristate_control_pin_out = {ais[1], ~tx_en[2], ais[0], ~tx_en[0]};
        endcase
    end

    assign tx_pin_out = {tx_q.level, tx_en};
    assign tx_tick_out = tx_tick;
    assign up_bit_pos_out = up_pos_q;
    assign down_bit_pos_out = down_pos_q;
    assign rx_bit_out = rx_bit_q;
    assign rx_valid_out = rx_valid_q;
    assign mismatch_out = mismatch_q;
    assign avs_readdata_out = rdata_q;
    assign avs_waitrequest_out = req & ~ack_q;

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (reset_in);

    bus_wait_a: assert property (req && !ack_q |-> avs_waitrequest_out ##1 (!req || !avs_waitrequest_out))
        else $error("bus answer not on second edge");
    offset_mask_a: assert property (mode == MODE_0
        |-> down_off == {2'h0, down_off_q} && up_off == {2'h0, up_off_q})
        else $error("mode 0 offset low bits not ignored");
    frame_start_a: assert property (frame_start |=> down_pos_q == $past(down_off) && up_pos_q == $past(up_off))
        else $error("frame start did not load offsets");
    tx_map_a: assert property (tx_tick && mode == MODE_1 |=> tx_pin_out.level[2] == $past(tx_bit_in[1]))
        else $error("logical port 1 not on third pin");
    standby_a: assert property (!port_active && mode != MODE_2
        |-> tx_pin_out.oe == 4'h0 && tristate_control_pin_out[0] && tristate_control_pin_out[2])
        else $error("standby pins not released");
    select_pin_a: assert property (mode == MODE_1
        |-> tristate_control_pin_out[1] == ais[0] && tristate_control_pin_out[3] == ais[1])
        else $error("select bits not on control pins");
    rx_sel_a: assert property (rx_tick && mode == MODE_1 && !test_loop && ais[0]
        |=> rx_bit_out[0] == $past(rx_s[0]))
        else $error("logical port 0 not from line 0");
    mode2_sel_a: assert property (rx_tick && mode == MODE_2 && !test_loop && !ais[1]
        |=> rx_bit_out[0] == $past(rx_s[3]))
        else $error("mode 2 input not from line 3");
    test_loop_a: assert property (rx_tick && mode == MODE_0 && test_loop |=> rx_bit_out == $past(tx_pin_out.level))
        else $error("loop did not return transmit data");
    mismatch_a: assert property (rx_tick && aic[0] && rx_src[0] != rx_src[1] |=> mismatch_out[0] ##1 mismatch_out[0])
        else $error("mismatch not held");

    // strobes and per-mode pin roles
    tx_launch_a: assert property (tx_tick |=> tx_q == $past(tx_next))
        else $error("transmit data not launched on the selected edge");
    rx_valid_a: assert property (rx_tick |=> rx_valid_out)
        else $error("receive sample not flagged");
    mode3_dup_a: assert property (tx_tick && mode == MODE_3
        |=> tx_pin_out.level[1] == tx_pin_out.level[0] && tx_pin_out.level[3] == tx_pin_out.level[2])
        else $error("mode 3 pins not duplicated");
    standby_m2_a: assert property (!port_active && mode == MODE_2
        |-> tx_pin_out.oe == 4'h0 && tristate_control_pin_out[0] && tristate_control_pin_out[2])
        else $error("mode 2 standby pins not released");
    // a disabled pair must leave its flag alone, whatever the lines do
    compare_off_a: assert property (aic == 2'h0 && mm_clear == 2'h0 |=> mismatch_q == $past(mismatch_q))
        else $error("disabled compare changed the flags");

    // frames are far longer than a delay range, so cover the reload itself
    frame_seen_c: cover property (frame_start ##1 (down_pos_q == $past(down_off)));
    loop_rx_c: cover property (test_loop && rx_tick);
    mismatch_c: cover property (!mismatch_q[1] ##1 mismatch_q[1]);
    standby_c: cover property (!port_active && tx_tick);
    loop_m3_c: cover property (test_loop && mode == MODE_3 && rx_tick);

endmodule : highway_port_config

// ==== highway_port_config_bench.sv ====
// self-checking bench for the highway port configuration block
`timescale 1ns/1ps
module highway_port_config_bench;
    import highway_port_pkg::*;
    logic clock_in, reset_in, rd, wr, wt, tick, rv, hc, fs;
    logic [2:0] adr;
    logic [31:0] wd, q, rdata;
    logic [3:0] tb, ts, rx, ctl, rb;
    logic [1:0] skew, mm, s;
    logic [9:0] dpos, upos;
    pin_group_t pins;
    int err_total, compares;

    highway_port_config highway_port_config_i (.clock_in(clock_in), .reset_in(reset_in),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(wt),
        .highway_clock_in(hc), .frame_sync_in(fs), .rx_line_in(rx), .tx_pin_out(pins),
        .tristate_control_pin_out(ctl), .tx_bit_in(tb), .tx_tristate_in(ts), .tx_tick_out(tick),
        .up_bit_pos_out(upos), .rx_bit_out(rb), .rx_valid_out(rv), .down_bit_pos_out(dpos),
        .mismatch_out(mm));
    highway_line_model highway_line_model_i (.skew_in(skew), .clock_out(hc), .sync_out(fs), .line_out(rx));

    initial begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    // starts one edge late so a release and a new request never share a time step
    task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_in);
        adr <= a;
        wr <= w;
        rd <= ~w;
        wd <= d;
        @(posedge clock_in);
        while (wt !== 1'b0 && n < 20) begin
            @(posedge clock_in);
            n++;
        end
        if (n == 20) chk("waitrequest", 32'h0, 32'h1);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus

    task automatic rdchk(input string n, input logic [2:0] a, input logic [31:0] k, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(n, e, q & k);
    endtask : rdchk

    task automatic setup(input logic [1:0] m, sel, c, input logic act, lp, input logic [7:0] sc);
        bus(1'b1, REG_HW_MODE, {24'h0, c, sel, 2'b01, m});
        bus(1'b1, REG_OP_MODE, {26'h0, act, lp, 4'h0});
        bus(1'b1, REG_SHIFT_CTRL, {24'h0, sc});
    endtask : setup

    task automatic wait_pulse(input logic rxs);
        int n;
        n = 0;
        do begin
            @(negedge clock_in);
            n++;
        end while ((rxs ? rv : tick) !== 1'b1 && n < 300);
        if (n == 300) chk("event wait", 32'h1, 32'h0);
    endtask : wait_pulse

    // offset in bit units: the mode decides how many low register bits drop out
    function automatic int ofs(input int m, input int v);
        return v >> (m == 0 ? 2 : m == 2 ? 0 : 1);
    endfunction : ofs

    function automatic int tgt(input int m, input bit up, input int v, input int b);
        int o, k;
        o = ofs(m, v);
        k = up ? (m == 0 ? 23 : m == 2 ? 95 : 47) : (m == 0 ? 17 : m == 2 ? 65 : 33);
        return up ? (o - k + b) % b : (o + k) % b;
    endfunction : tgt

    function automatic pin_group_t tx_map(input logic [1:0] m, input logic [3:0] b, input logic [3:0] t);
        logic [3:0] e;
        e = ~t;
        case (m)
            2'd0: return {b, e};
            2'd1: return {1'b0, b[1], 1'b0, b[0], 1'b0, e[1], 1'b0, e[0]};
            2'd2: return {3'b0, b[0], 3'b0, e[0]};
            default: return {b[1], b[1], b[0], b[0], e[1], e[1], e[0], e[0]};
        endcase
    endfunction : tx_map

    task automatic tx_step(input logic [1:0] m, input logic act);
        pin_group_t e;
        logic [3:0] c;
        @(posedge clock_in);
        tb <= 4'($urandom);
        ts <= 4'($urandom & $urandom);
        wait_pulse(1'b0);
        e = tx_map(m, tb, ts);
        e.oe = e.oe & {4{act}};
        @(posedge clock_in);
        #1;
        chk("tx enable", 32'(e.oe), 32'(pins.oe));
        chk("tx level", 32'(e.level & e.oe), 32'(pins.level & e.oe));
        c = m == 2'd0 ? ~e.oe : {s[1], ~e.oe[2], s[0], ~e.oe[0]};
        chk("control pins", 32'(c), 32'(ctl));
    endtask : tx_step

    task automatic rx_run(input logic [1:0] m, input logic lp, input int cnt);
        logic [3:0] l, e, k;
        pin_group_t p;
        for (int i = 0; i < cnt; i++) begin
            wait_pulse(1'b1);
            p = tx_map(m, tb, 4'h0);
            l = lp ? p.level : rx;
            k = m == 2'd0 ? 4'hF : m == 2'd2 ? 4'h1 : 4'h3;
            e = m == 2'd0 ? l : {2'b0, s[1] ? l[2] : l[3], s[0] ? l[0] : l[1]};
            if (m == 2'd2) e = {3'b0, s[1] ? l[2] : l[3]};
            if (i > 1) chk("rx bits", 32'(e & k), 32'(rb & k));
        end
    endtask : rx_run

    initial begin
        int v[7];
        int ex[2][7];
        logic [2:0] ad[5];
        ex = '{'{255, 4, 'hF1, 'h19, 'h01, 2, 2}, '{383, 5, 'hB1, 'h17, 'h11, 3, 383}};
        ad = '{REG_FRAME_LEN, REG_HW_MODE, REG_DOWN_OFFSET, REG_UP_OFFSET, REG_SHIFT_CTRL};
        void'($urandom(68));
        err_total = 0;
        compares = 0;
        {reset_in, rd, wr, adr, wd, tb, ts, skew, s} = {1'b1, 49'h0};
        repeat (3) @(posedge clock_in);
        reset_in <= 1'b0;
        for (int a = 0; a < 8; a++) begin
            rdchk("reset value", 3'(a), a == 6 ? 32'h3 : 32'hFFFF_FFFF,
                a == 5 ? 32'hFF : a == 7 ? 32'h00E9_0011 : 32'h0);
        end
        $display("test reset values done");
        // two fixed worked cases first, then random offsets kept below one frame
        for (int i = 0; i < 10; i++) begin
            if (i < 2) v = ex[i];
            else begin
                v[1] = 4 + $urandom_range(0, 3);
                v[2] = $urandom_range(0, 63);
                v[3] = $urandom_range(0, 63);
                v[4] = $urandom & 'h77;
                v[5] = tgt(v[1] - 4, 0, (v[2] << 2) | ((v[4] >> 5) & 3), 256);
                v[6] = tgt(v[1] - 4, 1, (v[3] << 2) | ((v[4] >> 1) & 3), 256);
                v[0] = 255;
            end
            foreach (ad[j]) bus(1'b1, ad[j], 32'(v[j]));
            bus(1'b1, REG_TARGET, 32'hFFFF_FFFF);
            rdchk("target bits", REG_TARGET, 32'h03FF_03FF, 32'((v[6] << 16) | v[5]));
        end
        // both counters reload at one frame start, so their gap is the offset gap
        @(posedge fs);
        repeat (40) @(negedge clock_in);
        chk("position gap", 32'((ofs(v[1] - 4, (v[3] << 2) | ((v[4] >> 1) & 3)) + 256
            - ofs(v[1] - 4, (v[2] << 2) | ((v[4] >> 5) & 3))) % 256),
            32'((int'(upos) + 256 - int'(dpos)) % 256));
        $display("test frame offsets done");
        for (int m = 0; m < 4; m++) begin
            for (int act = 0; act < 2; act++) begin
                s = m == 0 ? 2'b00 : 2'($urandom);
                setup(2'(m), s, 2'b00, 1'(act), 1'b0, 8'($urandom) & 8'h11);
                repeat (4) tx_step(2'(m), 1'(act));
            end
        end
        $display("test transmit pins done");
        s = 2'($urandom);
        setup(2'd1, s, 2'b10, 1'b0, 1'b0, 8'h11);
        skew <= 2'b01;
        rx_run(2'd1, 1'b0, 6);
        chk("mismatch", 32'h0, 32'(mm));
        skew <= 2'b10;
        rx_run(2'd1, 1'b0, 4);
        chk("mismatch", 32'h2, 32'(mm));
        rdchk("status", REG_STATUS, 32'h3, 32'h2);
        skew <= 2'b00;
        rx_run(2'd1, 1'b0, 3);
        bus(1'b1, REG_STATUS, 32'h3);
        rdchk("status", REG_STATUS, 32'h3, 32'h0);
        setup(2'd2, s, 2'b01, 1'b0, 1'b0, 8'h10);
        skew <= 2'b01;
        rx_run(2'd2, 1'b0, 4);
        chk("mismatch", 32'h1, 32'(mm));
        $display("test receive compare done");
        // lines carry noise so only looped data can match
        skew <= 2'b11;
        @(posedge clock_in);
        tb <= 4'($urandom);
        ts <= 4'h0;
        setup(2'd3, s, 2'b00, 1'b1, 1'b1, 8'h10);
        rx_run(2'd3, 1'b1, 6);
        s = 2'b00;
        setup(2'd0, s, 2'b00, 1'b1, 1'b1, 8'h10);
        rx_run(2'd0, 1'b1, 6);
        setup(2'd0, s, 2'b00, 1'b1, 1'b0, 8'h10);
        $display("test loop done");
        complete_run();
    end

    initial begin
        #(5 * 20000);
        err_total++;
        $display("watchdog expired");
        complete_run();
    end
endmodule : highway_port_config_bench

// ==== highway_port_pkg.sv ====
// constants, types and register map of the highway port configuration block
package highway_port_pkg;

    // register word index on the avalon bus (byte address = index * 4)
    localparam logic [2:0] REG_DOWN_OFFSET = 3'h0;
    localparam logic [2:0] REG_UP_OFFSET = 3'h1;
    localparam logic [2:0] REG_SHIFT_CTRL = 3'h2;
    localparam logic [2:0] REG_HW_MODE = 3'h3;
    localparam logic [2:0] REG_OP_MODE = 3'h4;
    localparam logic [2:0] REG_FRAME_LEN = 3'h5;
    localparam logic [2:0] REG_STATUS = 3'h6;
    localparam logic [2:0] REG_TARGET = 3'h7;

    // shift_control_reg fields
    localparam int SC_TX_EDGE = 0;
    localparam int SC_UP_LO = 1;
    localparam int SC_RX_EDGE = 4;
    localparam int SC_DOWN_LO = 5;
    // highway_mode_reg fields
    localparam int HM_MODE = 0;
    localparam int HM_SYNC_EDGE = 2;
    localparam int HM_AIS = 4;
    localparam int HM_AIC = 6;
    // operation_mode_reg fields
    localparam int OM_TEST_LOOP = 4;
    localparam int OM_PORT_ACTIVE = 5;
    // status and target fields
    localparam int ST_FS_LEVEL = 2;
    localparam int TG_UP = 16;

    // reset values
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [9:0] FRAME_LEN_RST = 10'h0FF;

    // frame offset constants per mode
    localparam logic [9:0] DOWN_K_M0 = 10'h011;
    localparam logic [9:0] DOWN_K_M13 = 10'h021;
    localparam logic [9:0] DOWN_K_M2 = 10'h041;
    localparam logic [9:0] UP_K_M0 = 10'h017;
    localparam logic [9:0] UP_K_M13 = 10'h02F;
    localparam logic [9:0] UP_K_M2 = 10'h05F;

    localparam int SYNC_WIDTH = 6;

    typedef enum logic [1:0] {
        MODE_0 = 2'b00,
        MODE_1 = 2'b01,
        MODE_2 = 2'b10,
        MODE_3 = 2'b11
    } hw_mode_t;

    // four transmit pins: level and output enable
    typedef struct packed {
        logic [3:0] level;
        logic [3:0] oe;
    } pin_group_t;

endpackage : highway_port_pkg

// ==== pin_sync.sv ====
// two-stage synchroniser for the highway pins
`timescale 1ns/1ps
module pin_sync
    import highway_port_pkg::*;
(
    // system
    input wire logic clock_in,
    input wire logic reset_in,
    // pins
    input wire logic [SYNC_WIDTH-1:0] pins_in,
    output logic [SYNC_WIDTH-1:0] pins_out
);
    logic [SYNC_WIDTH-1:0] meta_q;
    logic [SYNC_WIDTH-1:0] sync_q;

    // meta_q feeds only sync_q
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= pins_in;
            sync_q <= meta_q;
        end
    end

    assign pins_out = sync_q;

endmodule : pin_sync
